// ---- common/tmr2_params.svh ----
// Constants for the capture/reload timer: register offsets, bit positions, reset values, timing.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
`ifndef TMR2_PARAMS_SVH
`define TMR2_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TMR2_OFF_CTRL     8'h00
`define TMR2_OFF_COUNT    8'h04
`define TMR2_OFF_CAPTURE  8'h08
`define TMR2_OFF_IRQ_STAT 8'h0C
`define TMR2_OFF_IRQ_MASK 8'h10

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define TMR2_BIT_OVF  7
`define TMR2_BIT_EXF  6
`define TMR2_BIT_RCLK 5
`define TMR2_BIT_TX_CLOCK_SELECT 4
`define TMR2_BIT_EXEN 3
`define TMR2_BIT_RUN  2
`define TMR2_BIT_CT   1
`define TMR2_BIT_CPRL 0

// Interrupt status bit positions
`define TMR2_IRQ_OVF 0
`define TMR2_IRQ_EXF 1

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TMR2_CTRL_RST  8'h00
`define TMR2_WORD_RST  16'h0000
`define TMR2_PRESCALE  12
`define TMR2_CNT_MAX   16'hFFFF
`define TMR2_CNT_WRAP  16'h0000

`endif

// ---- common/tmr2_pkg.sv ----
// Types shared by the capture/reload timer.
// Assumes nothing of its surroundings.
`default_nettype none
package tmr2_pkg;
  typedef enum logic [3:0] {
    TMR2_OFF     = 4'b0001,
    TMR2_RELOAD  = 4'b0010,
    TMR2_CAPTURE = 4'b0100,
    TMR2_BAUD    = 4'b1000
  } tmr2_mode_t;
endpackage
`default_nettype wire

// ---- src/tmr2_timer.sv ----
// Third 16-bit timer/counter with capture, auto-reload and baud generator modes.
// Assumes a classic Wishbone master on the core clock, and count/trigger pins synchronous-ish to it.
//
// Function
// - Count source select 0 counts the clock divided by twelve, 1 counts falling edges of the count input.
// - Serial selects both 0 choose reload (select 0) or capture (select 1), either serial select gives baud mode, run 0 stops.
// - Run control 1 starts counting and 0 halts it keeping the count.
// - Capture mode counts freely and sets the overflow flag on each overflow, which may interrupt.
// - Capture mode with external enable copies the count into the capture registers on a trigger fall and sets the external flag.
// - Reload mode reloads from the capture registers and sets the overflow flag on each rollover.
// - Reload mode with external enable also reloads and sets the external flag on a trigger fall.
// - The overflow flag is set by hardware or a software write, cleared only by software, and never set by an overflow in baud mode.
// - The external flag sets on a trigger-caused capture or reload, may interrupt, and only software clears it.
// - Receive clock select 1 routes this timer's overflows to the serial receiver, else timer 1 overflows.
// - Transmit clock select 1 routes this timer's overflows to the serial transmitter, else timer 1 overflows.
// - Trigger falls act only with external enable set and outside baud mode.
// - In baud mode the capture/reload select is ignored and every overflow reloads.
`include "tmr2_params.svh"
`default_nettype none
module tmr2_timer
  import tmr2_pkg::*;
#(
  parameter int PRESCALE = `TMR2_PRESCALE
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Pins
  input  wire logic        count_in_i,
  input  wire logic        trigger_pin_i,
  // Serial port clocking
  input  wire logic        t1_overflow_i,
  output logic             rx_clock_o,
  output logic             tx_clock_o,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] capture_reg;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_mask_reg;
  logic [1:0]  cnt_sync_reg;
  logic [1:0]  trg_sync_reg;
  logic        cnt_prev_reg;
  logic        trg_prev_reg;
  logic [3:0]  presc_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic        bus_req;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_capture;
  logic        wr_stat;
  logic        wr_mask;
  logic        addr_ok;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  assign bus_req    = cyc_i & stb_i & ~ack_o & ~err_o;
  assign addr_ok    = hit(adr_i, `TMR2_OFF_CTRL) | hit(adr_i, `TMR2_OFF_COUNT) |
                      hit(adr_i, `TMR2_OFF_CAPTURE) | hit(adr_i, `TMR2_OFF_IRQ_STAT) |
                      hit(adr_i, `TMR2_OFF_IRQ_MASK);
  assign wr_ctrl    = bus_req & we_i & sel_i[0] & hit(adr_i, `TMR2_OFF_CTRL);
  assign wr_count   = bus_req & we_i & hit(adr_i, `TMR2_OFF_COUNT);
  assign wr_capture = bus_req & we_i & hit(adr_i, `TMR2_OFF_CAPTURE);
  assign wr_stat    = bus_req & we_i & sel_i[0] & hit(adr_i, `TMR2_OFF_IRQ_STAT);
  assign wr_mask    = bus_req & we_i & sel_i[0] & hit(adr_i, `TMR2_OFF_IRQ_MASK);

  // ----------------------------------------
  // Mode and event decode
  // ----------------------------------------
  tmr2_mode_t mode;
  logic       baud_sel;
  logic       tick;
  logic       presc_tick;
  logic       cnt_fall;
  logic       trg_fall;
  logic       trg_event;
  logic       overflow;
  logic       ovf_set;
  logic       exf_set;

  assign baud_sel = ctrl_reg[`TMR2_BIT_RCLK] | ctrl_reg[`TMR2_BIT_TX_CLOCK_SELECT];

  always_comb begin
    if (!ctrl_reg[`TMR2_BIT_RUN]) begin
      mode = TMR2_OFF;
    end else if (baud_sel) begin
      mode = TMR2_BAUD;
    end else if (ctrl_reg[`TMR2_BIT_CPRL]) begin
      mode = TMR2_CAPTURE;
    end else begin
      mode = TMR2_RELOAD;
    end
  end

  // Edge detectors read only the second synchroniser stage
  assign cnt_fall   = cnt_prev_reg & ~cnt_sync_reg[1];
  assign trg_fall   = trg_prev_reg & ~trg_sync_reg[1];
  assign presc_tick = (presc_reg == 4'(PRESCALE - 1));
  assign tick       = ctrl_reg[`TMR2_BIT_CT] ? cnt_fall : presc_tick;
  assign overflow   = (mode != TMR2_OFF) & tick & (count_reg == `TMR2_CNT_MAX);
  assign trg_event  = trg_fall & ctrl_reg[`TMR2_BIT_EXEN] & ~baud_sel
                      & (mode != TMR2_OFF);
  assign ovf_set    = overflow & ~baud_sel;
  assign exf_set    = trg_event;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_sync_reg <= 2'h3;
      trg_sync_reg <= 2'h3;
      cnt_prev_reg <= 1'h1;
      trg_prev_reg <= 1'h1;
    end else begin
      cnt_sync_reg <= {cnt_sync_reg[0], count_in_i};
      trg_sync_reg <= {trg_sync_reg[0], trigger_pin_i};
      cnt_prev_reg <= cnt_sync_reg[1];
      trg_prev_reg <= trg_sync_reg[1];
    end
  end

  // Prescaler runs only while enabled so the first tick is a full period away
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_reg[`TMR2_BIT_RUN] || presc_tick) begin
      presc_reg <= 4'h0;
    end else begin
      presc_reg <= presc_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // Control register with hardware flags
  // ----------------------------------------
  // Hardware set beats a software clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `TMR2_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= dat_i[7:0];
      end
      if (ovf_set) begin
        ctrl_reg[`TMR2_BIT_OVF] <= 1'b1;
      end
      if (exf_set) begin
        ctrl_reg[`TMR2_BIT_EXF] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= `TMR2_WORD_RST;
    end else if (wr_count) begin
      if (sel_i[0]) count_reg[7:0]  <= dat_i[7:0];
      if (sel_i[1]) count_reg[15:8] <= dat_i[15:8];
    end else if (trg_event && mode == TMR2_RELOAD) begin
      count_reg <= capture_reg;
    end else if (overflow && mode != TMR2_CAPTURE) begin
      count_reg <= capture_reg;
    end else if (mode != TMR2_OFF && tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Capture register doubles as the reload value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_reg <= `TMR2_WORD_RST;
    end else if (trg_event && mode == TMR2_CAPTURE) begin
      capture_reg <= count_reg;
    end else if (wr_capture) begin
      if (sel_i[0]) capture_reg[7:0]  <= dat_i[7:0];
      if (sel_i[1]) capture_reg[15:8] <= dat_i[15:8];
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      irq_o        <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? dat_i[1:0] : 2'h0))
                      | {exf_set, ovf_set};
      if (wr_mask) irq_mask_reg <= dat_i[1:0];
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------
  // Serial port clocks
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_clock_o <= 1'b0;
      tx_clock_o <= 1'b0;
    end else begin
      rx_clock_o <= ctrl_reg[`TMR2_BIT_RCLK] ? overflow : t1_overflow_i;
      tx_clock_o <= ctrl_reg[`TMR2_BIT_TX_CLOCK_SELECT] ? overflow : t1_overflow_i;
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req & addr_ok;
      err_o <= bus_req & ~addr_ok;
      dat_o <= 32'h0000_0000;
      if (bus_req && !we_i) begin
        case (adr_i)
          `TMR2_OFF_CTRL:     dat_o <= {24'h000000, ctrl_reg};
          `TMR2_OFF_COUNT:    dat_o <= {16'h0000, count_reg};
          `TMR2_OFF_CAPTURE:  dat_o <= {16'h0000, capture_reg};
          `TMR2_OFF_IRQ_STAT: dat_o <= {30'h0, irq_stat_reg};
          `TMR2_OFF_IRQ_MASK: dat_o <= {30'h0, irq_mask_reg};
          default:            dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  no_ovf_baud_a: assert property (@(posedge clk_i) disable iff (rst_i)
    baud_sel && !ctrl_reg[`TMR2_BIT_OVF] && !wr_ctrl |=> !ctrl_reg[`TMR2_BIT_OVF])
    else $error("overflow flag set in baud mode");

  ovf_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[`TMR2_BIT_OVF] && !wr_ctrl |=> ctrl_reg[`TMR2_BIT_OVF])
    else $error("overflow flag lost without a write");

  ext_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[`TMR2_BIT_EXF] && !wr_ctrl |=> ctrl_reg[`TMR2_BIT_EXF])
    else $error("external flag lost without a write");

  halt_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_reg[`TMR2_BIT_RUN] && !wr_count |=> count_reg == $past(count_reg))
    else $error("count moved while halted");

  reload_roll_a: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow && mode == TMR2_RELOAD && !wr_count |=> count_reg == $past(capture_reg))
    else $error("no reload on rollover");

  ovf_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow && !baud_sel |=> ctrl_reg[`TMR2_BIT_OVF] && irq_stat_reg[`TMR2_IRQ_OVF])
    else $error("overflow flag missed");

  capture_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trg_event && mode == TMR2_CAPTURE |=> capture_reg == $past(count_reg) && ctrl_reg[`TMR2_BIT_EXF])
    else $error("capture missed");

  trig_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trg_event && mode == TMR2_RELOAD && !wr_count |=> count_reg == $past(capture_reg))
    else $error("trigger reload missed");

  trig_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trg_fall && !ctrl_reg[`TMR2_BIT_EXEN] && !wr_capture |=> capture_reg == $past(capture_reg))
    else $error("trigger acted while disabled");

  baud_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[`TMR2_BIT_RCLK] |=> rx_clock_o == $past(overflow))
    else $error("receive clock route wrong");

  tx_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_reg[`TMR2_BIT_TX_CLOCK_SELECT] |=> tx_clock_o == $past(t1_overflow_i))
    else $error("transmit clock route wrong");

  rx_t1_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_reg[`TMR2_BIT_RCLK] |=> rx_clock_o == $past(t1_overflow_i))
    else $error("receive clock not from timer 1");

  tx_baud_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[`TMR2_BIT_TX_CLOCK_SELECT] |=> tx_clock_o == $past(overflow))
    else $error("transmit clock not from overflow");

  free_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow && mode == TMR2_CAPTURE && !wr_count |=> count_reg == `TMR2_CNT_WRAP)
    else $error("capture mode did not wrap freely");

  count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode == TMR2_CAPTURE && tick && !overflow && !wr_count |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not step on a tick");

  baud_no_trig_a: assert property (@(posedge clk_i) disable iff (rst_i)
    trg_fall && baud_sel && !wr_capture |=> capture_reg == $past(capture_reg))
    else $error("trigger acted in baud mode");

  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> irq_o == $past(|(irq_stat_reg & irq_mask_reg)))
    else $error("interrupt level wrong");

  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held for more than a cycle");

  // Running-cycle count kept apart from the prescaler, so the check is not a copy of it
  int run_cycles;

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_reg[`TMR2_BIT_RUN]) begin
      run_cycles <= 0;
    end else begin
      run_cycles <= run_cycles + 1;
    end
  end

  prescale_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_reg[`TMR2_BIT_RUN] |-> presc_tick == ((run_cycles % PRESCALE) == PRESCALE - 1))
    else $error("prescaler tick out of step");

endmodule
`default_nettype wire

// ---- testbench/tmr2_pins_model.sv ----
// Far-side model: count and trigger pins, timer 1 overflow source, serial clock counters.
// Assumes the timer samples its pins on the rising edge of clk_i.
`default_nettype none
module tmr2_pins_model (
  // Clock
  input  wire logic clk_i,
  // Pins toward the timer
  output logic      count_in_o,
  output logic      trigger_o,
  output logic      t1_ovf_o,
  // Serial clocks from the timer
  input  wire logic rx_clock_i,
  input  wire logic tx_clock_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int rx_cnt = 0;
  int tx_cnt = 0;
  int t1_cnt = 0;
  int div    = 0;
  initial begin
    count_in_o = 1'b1;
    trigger_o  = 1'b1;
    t1_ovf_o   = 1'b0;
  end
  // Timer 1 overflow free-runs at one pulse in five cycles
  always @(posedge clk_i) begin
    div      <= (div == 4) ? 0 : div + 1;
    t1_ovf_o <= (div == 4);
    if (div == 4) t1_cnt <= t1_cnt + 1;
    if (rx_clock_i === 1'b1) rx_cnt <= rx_cnt + 1;
    if (tx_clock_i === 1'b1) tx_cnt <= tx_cnt + 1;
  end
  // Each level held four cycles, so the synchroniser sees both
  task automatic fall(input bit trig);
    repeat (4) @(posedge clk_i);
    if (trig) trigger_o <= 1'b0;
    else count_in_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    trigger_o  <= 1'b1;
    count_in_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tmr2_timer_tb_top.sv ----
// Self-checking bench for the capture/reload timer.
// Assumes a Wishbone slave answering with ack or err one cycle after the request.
`include "tmr2_params.svh"
`default_nettype none
module tmr2_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PRE = 2;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, q;
  logic        ack_o, err_o, e, cnt_in, trig, t1_ovf, rx_clk, tx_clk, irq_o;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          seed = 32'h3c73;
  int          exp_cnt, r0, t0, d, x0;
  tmr2_timer #(.PRESCALE(PRE)) tmr2_timer_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .count_in_i(cnt_in), .trigger_pin_i(trig), .t1_overflow_i(t1_ovf), .rx_clock_o(rx_clk),
    .tx_clock_o(tx_clk), .irq_o(irq_o));
  tmr2_pins_model tmr2_pins_model_i (.clk_i(clk_i), .count_in_o(cnt_in), .trigger_o(trig),
    .t1_ovf_o(t1_ovf), .rx_clock_i(rx_clk), .tx_clock_i(tx_clk));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run;
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x, input string m);
    samples_checked++;
    if (s !== x) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Request held until ack or err is sampled high at a rising edge; only the bench timeout ends a wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= v;
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
    bus(1'b0, a, 32'h0);
    check(q, x, m);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    wt(8);
    rst_i <= 1'b0;
    rd(`TMR2_OFF_CTRL, 32'h0, "ctrl reset");
    rd(8'h40, 32'h0, "unmapped data");
    check(e, 1'b1, "unmapped err");
    bus(1'b1, `TMR2_OFF_CAPTURE, 32'hFFF0);
    bus(1'b1, `TMR2_OFF_COUNT, 32'hFFF0);
    bus(1'b1, `TMR2_OFF_CTRL, 32'h04);
    wt(16 * PRE + 20);
    bus(1'b0, `TMR2_OFF_CTRL, 32'h0);
    check(q[7], 1'b1, "reload ovf flag");
    bus(1'b0, `TMR2_OFF_COUNT, 32'h0);
    check(q[15:0] >= 16'hFFF0, 1'b1, "reload value");
    bus(1'b1, `TMR2_OFF_CTRL, 32'h00);
    bus(1'b0, `TMR2_OFF_COUNT, 32'h0);
    r0 = q;
    wt(20);
    rd(`TMR2_OFF_COUNT, r0, "halted count");
    rd(`TMR2_OFF_IRQ_STAT, 32'h1, "ovf status");
    check(irq_o, 1'b0, "irq masked");
    bus(1'b1, `TMR2_OFF_IRQ_MASK, 32'h3);
    wt(2);
    check(irq_o, 1'b1, "irq ovf");
    bus(1'b1, `TMR2_OFF_IRQ_STAT, 32'h1);
    wt(2);
    check(irq_o, 1'b0, "irq cleared");
    exp_cnt = $random(seed) & 32'h0FFF;
    bus(1'b1, `TMR2_OFF_COUNT, exp_cnt);
    bus(1'b1, `TMR2_OFF_CTRL, 32'h0F);
    repeat (3) begin
      tmr2_pins_model_i.fall(1'b0);
      exp_cnt++;
    end
    wt(6);
    rd(`TMR2_OFF_COUNT, exp_cnt, "event count");
    tmr2_pins_model_i.fall(1'b1);
    wt(6);
    rd(`TMR2_OFF_CAPTURE, exp_cnt, "capture");
    rd(`TMR2_OFF_CTRL, 32'h4F, "ext flag");
    check(irq_o, 1'b1, "irq ext");
    bus(1'b1, `TMR2_OFF_IRQ_STAT, 32'h2);
    bus(1'b1, `TMR2_OFF_CTRL, 32'h07);
    rd(`TMR2_OFF_CTRL, 32'h07, "flag cleared");
    tmr2_pins_model_i.fall(1'b1);
    wt(6);
    rd(`TMR2_OFF_CAPTURE, exp_cnt, "no capture");
    rd(`TMR2_OFF_CTRL, 32'h07, "no ext flag");
    bus(1'b1, `TMR2_OFF_CAPTURE, 32'h00AA);
    bus(1'b1, `TMR2_OFF_CTRL, 32'h0E);
    tmr2_pins_model_i.fall(1'b1);
    wt(6);
    rd(`TMR2_OFF_COUNT, 32'h00AA, "trigger reload");
    rd(`TMR2_OFF_CTRL, 32'h4E, "reload ext flag");
    bus(1'b1, `TMR2_OFF_CAPTURE, 32'hFFF0);
    bus(1'b1, `TMR2_OFF_COUNT, 32'hFFF0);
    bus(1'b1, `TMR2_OFF_CTRL, 32'h3D);
    r0 = tmr2_pins_model_i.rx_cnt;
    t0 = tmr2_pins_model_i.tx_cnt;
    tmr2_pins_model_i.fall(1'b1);
    wt(200);
    check(tmr2_pins_model_i.rx_cnt - r0 >= 5, 1'b1, "rx baud");
    check(tmr2_pins_model_i.tx_cnt - t0 >= 5, 1'b1, "tx baud");
    rd(`TMR2_OFF_CTRL, 32'h3D, "baud flags");
    bus(1'b1, `TMR2_OFF_CTRL, 32'h24);
    r0 = tmr2_pins_model_i.t1_cnt;
    x0 = tmr2_pins_model_i.rx_cnt;
    t0 = tmr2_pins_model_i.tx_cnt;
    wt(100);
    d = (tmr2_pins_model_i.tx_cnt - t0) - (tmr2_pins_model_i.t1_cnt - r0);
    check(d >= -1 && d <= 1, 1'b1, "tx from timer 1");
    check(tmr2_pins_model_i.rx_cnt - x0 >= 2, 1'b1, "rx still baud");
    bus(1'b1, `TMR2_OFF_CTRL, 32'h00);
    bus(1'b1, `TMR2_OFF_COUNT, 32'hFFF8);
    bus(1'b1, `TMR2_OFF_CAPTURE, 32'h1234);
    bus(1'b1, `TMR2_OFF_CTRL, 32'h05);
    wt(20);
    rd(`TMR2_OFF_CTRL, 32'h85, "capture ovf flag");
    bus(1'b0, `TMR2_OFF_COUNT, 32'h0);
    check(q[15:0] < 16'h0010, 1'b1, "free wrap");
    rd(`TMR2_OFF_CAPTURE, 32'h1234, "no reload in capture");
    rst_i <= 1'b1;
    wt(2);
    rst_i <= 1'b0;
    rd(`TMR2_OFF_CTRL, 32'h0, "ctrl after reset");
    rd(`TMR2_OFF_COUNT, 32'h0, "count after reset");
    rd(`TMR2_OFF_IRQ_STAT, 32'h0, "status after reset");
    check(irq_o, 1'b0, "irq after reset");
    complete_run();
  end
endmodule
`default_nettype wire
